// *** rtl/iod_decoder.sv ***
// Purpose: Decodes core accesses to the I/O space and holds the block's own registers.
// Assumes: One request at most per cycle; peripherals answer reads combinationally.
// Notes:   Every request is answered two cycles after it is taken.
`timescale 1ns/1ps
module iod_decoder (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_acc_valid,
  input  wire logic [2:0] i_acc_kind,
  input  wire logic       i_acc_write,
  input  wire logic [8:0] i_acc_addr,
  input  wire logic [2:0] i_acc_bit,
  input  wire logic [7:0] i_acc_wdata,
  input  wire logic [7:0] i_flag_set,
  input  wire logic       i_per_hit,
  input  wire logic [7:0] i_per_rdata,
  output logic            o_per_rd,
  output logic            o_per_wr,
  output logic      [8:0] o_per_addr,
  output logic      [7:0] o_per_wdata,
  output logic      [7:0] o_per_wmask,
  output logic            o_ack,
  output logic      [7:0] o_rdata,
  output logic            o_bit_value,
  output logic            o_skip,
  output logic            o_refused
);

  // Whole state of the decoder.
  typedef struct packed {
    iod_pkg::iod_stage_t s1;        // Access acting on the registers this cycle.
    logic                ack;       // Answer strobe.
    logic [7:0]          rdata;     // Answer data.
    logic                bitv;      // Value of the tested bit.
    logic                skip;      // Test outcome.
    logic                refused;   // Access was refused.
    logic                test;      // Answer belongs to a bit test.
    logic                test_set;  // That test skips on a set bit.
    logic [2:0][7:0]     scr;       // The three storage registers.
  } iod_main_t;

  iod_main_t st_q;                  // Registered state.
  iod_main_t st_d;                  // Next state.
  iod_reg_if flag_bus ();           // Path to the flag register.
  logic [2:0] scr_hit;              // Stage one addresses a storage register.
  logic       flag_hit;             // Stage one addresses the flag register.
  logic       own_hit;              // Stage one addresses a register kept here.
  logic       go;                   // Stage one may act on a register.
  logic [7:0] rd_val;               // Value read in stage one.

  // Turns a requested address into a data-space address.
  function automatic logic [8:0] to_data_addr(input logic [2:0] kind, input logic [8:0] addr);
    if (kind == iod_pkg::IOD_K_DATA) begin
      return addr;
    end
    return 9'(addr + iod_pkg::IO_OFFSET);
  endfunction

  // Says whether an access kind may reach the requested address.
  function automatic logic is_legal(input logic [2:0] kind, input logic [8:0] addr);
    case (kind)
      iod_pkg::IOD_K_DATA: return addr >= iod_pkg::DS_IO_FIRST;
      iod_pkg::IOD_K_PORT: return addr <= iod_pkg::SHORT_IO_LAST;
      iod_pkg::IOD_K_BSET, iod_pkg::IOD_K_BCLR,
      iod_pkg::IOD_K_TSET, iod_pkg::IOD_K_TCLR: return addr <= iod_pkg::BIT_IO_LAST;
      default: return 1'b0;
    endcase
  endfunction

  // Hit decode on the stage one address.
  assign scr_hit[0] = st_q.s1.addr == iod_pkg::SCR0_DS;
  assign scr_hit[1] = st_q.s1.addr == iod_pkg::SCR1_DS;
  assign scr_hit[2] = st_q.s1.addr == iod_pkg::SCR2_DS;
  assign flag_hit   = st_q.s1.addr == iod_pkg::FLAG_DS;
  assign own_hit    = (|scr_hit) || flag_hit;
  assign go         = st_q.s1.v && !st_q.s1.refused;

  // Peripheral strobes go out only for addresses this block does not hold.
  assign o_per_rd    = go && !st_q.s1.wr && !own_hit;
  assign o_per_wr    = go && st_q.s1.wr && !own_hit;
  assign o_per_addr  = st_q.s1.addr;
  assign o_per_wdata = st_q.s1.wdata;
  assign o_per_wmask = st_q.s1.wmask;

  // Flag register writes carry the mask, so one bit op clears one flag only.
  assign flag_bus.wr_en   = go && st_q.s1.wr && flag_hit;
  assign flag_bus.wr_mask = st_q.s1.wmask;
  assign flag_bus.wr_data = st_q.s1.wdata;

  // Answer outputs come straight from their flip-flops.
  assign o_ack       = st_q.ack;
  assign o_rdata     = st_q.rdata;
  assign o_bit_value = st_q.bitv;
  assign o_skip      = st_q.skip;
  assign o_refused   = st_q.refused;

  // Flags that hardware sets and software clears with a written one.
  iod_flag_reg #(
    .FLAG_W (8)
  ) u_flags (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_set    (i_flag_set),
    .bus      (flag_bus)
  );

  // Picks the value that stage one reads; unmapped places read zero.
  always_comb begin
    rd_val = 8'h00;
    if (go) begin
      if (flag_hit) begin
        rd_val = flag_bus.rd_data;
      end else if (scr_hit[0]) begin
        rd_val = st_q.scr[0];
      end else if (scr_hit[1]) begin
        rd_val = st_q.scr[1];
      end else if (scr_hit[2]) begin
        rd_val = st_q.scr[2];
      end else if (i_per_hit) begin
        rd_val = i_per_rdata;
      end
    end
  end

  // Decodes the request into stage one, acts on stage one, and forms the answer.
  always_comb begin
    logic [2:0] kind;
    logic [7:0] onehot;
    logic       bitop;
    kind   = i_acc_kind;
    onehot = 8'h01 << i_acc_bit;
    bitop  = (kind == iod_pkg::IOD_K_BSET) || (kind == iod_pkg::IOD_K_BCLR);
    st_d   = st_q;
    // Stage one takes the new request.
    st_d.s1.v         = i_acc_valid;
    st_d.s1.refused   = !is_legal(kind, i_acc_addr);
    st_d.s1.from_data = kind == iod_pkg::IOD_K_DATA;
    st_d.s1.bitop     = bitop;
    st_d.s1.test      = (kind == iod_pkg::IOD_K_TSET) || (kind == iod_pkg::IOD_K_TCLR);
    st_d.s1.test_set  = kind == iod_pkg::IOD_K_TSET;
    st_d.s1.bitn      = i_acc_bit;
    st_d.s1.addr      = to_data_addr(kind, i_acc_addr);
    if (bitop) begin
      // A bit op writes one bit under a one-hot mask.
      st_d.s1.wr    = 1'b1;
      st_d.s1.wmask = onehot;
      st_d.s1.wdata = (kind == iod_pkg::IOD_K_BSET) ? onehot : 8'h00;
    end else begin
      // Loads, stores and port transfers move the whole byte.
      st_d.s1.wr    = i_acc_write && !st_d.s1.test;
      st_d.s1.wmask = 8'hff;
      st_d.s1.wdata = i_acc_wdata;
    end
    // Storage registers keep exactly the bits written under the mask.
    for (int i = 0; i < 3; i++) begin
      if (go && st_q.s1.wr && scr_hit[i]) begin
        st_d.scr[i] = (st_q.scr[i] & ~st_q.s1.wmask) | (st_q.s1.wdata & st_q.s1.wmask);
      end
    end
    // The answer follows stage one by one cycle.
    st_d.ack      = st_q.s1.v;
    st_d.refused  = st_q.s1.v && st_q.s1.refused;
    st_d.rdata    = st_q.s1.wr ? 8'h00 : rd_val;
    st_d.test     = st_q.s1.v && st_q.s1.test;
    st_d.test_set = st_q.s1.test_set;
    st_d.bitv     = rd_val[st_q.s1.bitn];
    st_d.skip     = go && st_q.s1.test && (rd_val[st_q.s1.bitn] == st_q.s1.test_set);
  end

  // Registers the state, with a synchronous reset.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_q     <= '0;
      st_q.scr <= {3{iod_pkg::SCR_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // Every request is answered exactly two cycles later.
  answer_latency_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_acc_valid |-> ##2 o_ack)
    else $error("A request was not answered after two cycles.");

  // Bit set or clear above the low range is refused.
  bitop_range_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_acc_valid && (i_acc_kind == iod_pkg::IOD_K_BSET || i_acc_kind == iod_pkg::IOD_K_BCLR)
      && i_acc_addr > iod_pkg::BIT_IO_LAST) |-> ##2 (o_ack && o_refused))
    else $error("A bit operation above the low range was accepted.");

  // A test answers with the skip that matches the tested bit.
  bit_test_skip_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_ack && st_q.test && !o_refused) |-> (o_skip == (o_bit_value == st_q.test_set)))
    else $error("Skip does not match the tested bit.");

  // A port transfer above the short range is refused.
  port_range_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_acc_valid && i_acc_kind == iod_pkg::IOD_K_PORT && i_acc_addr > iod_pkg::SHORT_IO_LAST)
      |-> ##2 o_refused)
    else $error("A port transfer above the short range was accepted.");

  // Short addresses land at their data address.
  io_offset_map_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_acc_valid && i_acc_kind == iod_pkg::IOD_K_PORT)
      |=> (st_q.s1.addr == 9'($past(i_acc_addr) + iod_pkg::IO_OFFSET)))
    else $error("Short address was not offset by 0x20.");

  // Only loads and stores reach the extended range.
  ext_data_only_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    ((o_per_rd || o_per_wr) && o_per_addr >= iod_pkg::EXT_FIRST) |-> st_q.s1.from_data)
    else $error("Extended range reached by a short-address access.");

  // A bit op drives a single mask bit.
  single_bit_mask_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_per_wr && st_q.s1.bitop) |-> $onehot(o_per_wmask))
    else $error("A bit operation touched more than one bit.");

  // A store to the storage register at 0x4A is kept.
  scratch_store_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_acc_valid && i_acc_kind == iod_pkg::IOD_K_DATA && i_acc_write
      && i_acc_addr == iod_pkg::SCR1_DS)
      |-> ##2 (st_q.scr[1] == $past(i_acc_wdata, 2)))
    else $error("Storage register did not keep the stored byte.");

  // Refused accesses read zero and strobe no peripheral.
  refused_quiet_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (st_q.s1.v && st_q.s1.refused) |-> (!o_per_rd && !o_per_wr ##1 o_rdata == 8'h00))
    else $error("A refused access disturbed the bus or read non-zero.");

endmodule

// *** rtl/iod_pkg.sv ***
// Purpose: Shared constants and types of the I/O space address decoder.
// Assumes: Data addresses are 9 bits wide and every I/O register is 8 bits wide.
// Notes:   Short I/O addresses are range-checked as given, then turned into data addresses before the register hit decode.
package iod_pkg;

  // Width of a data-space address and of one I/O register.
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Distance between a short I/O address and its data-space address.
  localparam logic [8:0] IO_OFFSET     = 9'h020;
  // Last short I/O address that the port in/out operations can name.
  localparam logic [8:0] SHORT_IO_LAST = 9'h03f;
  // Last short I/O address that the single-bit operations can name.
  localparam logic [8:0] BIT_IO_LAST   = 9'h01f;
  // First data address of the I/O space; below it lie the working registers.
  localparam logic [8:0] DS_IO_FIRST   = 9'h020;
  // First data address of the extended I/O range.
  localparam logic [8:0] EXT_FIRST     = 9'h060;

  // Short I/O addresses of the storage and flag registers kept inside the block.
  localparam logic [8:0] SCR0_IO = 9'h01c;
  localparam logic [8:0] FLAG_IO = 9'h01d;
  localparam logic [8:0] SCR1_IO = 9'h02a;
  localparam logic [8:0] SCR2_IO = 9'h02b;

  // The same registers as data-space addresses.
  localparam logic [8:0] SCR0_DS = SCR0_IO + IO_OFFSET;
  localparam logic [8:0] FLAG_DS = FLAG_IO + IO_OFFSET;
  localparam logic [8:0] SCR1_DS = SCR1_IO + IO_OFFSET;
  localparam logic [8:0] SCR2_DS = SCR2_IO + IO_OFFSET;

  // Reset values of the storage and flag registers.
  localparam logic [7:0] SCR_RST  = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;

  // Kinds of access that the core may request.
  typedef enum logic [2:0] {
    IOD_K_DATA = 3'h0,  // Data-space load or store.
    IOD_K_PORT = 3'h1,  // Short-address port input or output.
    IOD_K_BSET = 3'h2,  // Single-bit set.
    IOD_K_BCLR = 3'h3,  // Single-bit clear.
    IOD_K_TSET = 3'h4,  // Skip if the selected bit is set.
    IOD_K_TCLR = 3'h5   // Skip if the selected bit is clear.
  } iod_kind_t;

  // One decoded access, held for the cycle in which it acts on a register.
  typedef struct packed {
    logic       v;          // An access is in this stage.
    logic       wr;         // The access writes.
    logic       refused;    // The access named an address its kind cannot reach.
    logic       from_data;  // The access came as a data-space load or store.
    logic       bitop;      // The access is a single-bit set or clear.
    logic       test;       // The access is a bit test.
    logic       test_set;   // The test skips on a set bit.
    logic [2:0] bitn;       // Selected bit.
    logic [8:0] addr;       // Data-space address.
    logic [7:0] wdata;      // Write data.
    logic [7:0] wmask;      // Bits that the write may touch.
  } iod_stage_t;

endpackage

// *** rtl/iod_reg_if.sv ***
// Purpose: Write and read path between the decoder and its flag register.
// Assumes: One clock; the write acts at the clock edge that ends the cycle.
// Notes:   Read data is combinational from the register.
`timescale 1ns/1ps
interface iod_reg_if;
  logic       wr_en;    // Write strobe.
  logic [7:0] wr_mask;  // Bits the write may touch.
  logic [7:0] wr_data;  // Write data.
  logic [7:0] rd_data;  // Present register value.
  modport ctrl (output wr_en, output wr_mask, output wr_data, input rd_data);
  modport regs (input wr_en, input wr_mask, input wr_data, output rd_data);
endinterface

// *** rtl/iod_flag_reg.sv ***
// Purpose: Status flags that hardware sets and software clears by writing one.
// Assumes: Set inputs come from logic on the same clock.
// Notes:   A set and a clear of the same flag in one cycle leaves the flag set.
`timescale 1ns/1ps
module iod_flag_reg #(
  parameter int FLAG_W = 8  // Number of flags, filled from bit 0 upward.
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic [FLAG_W-1:0] i_set,
  iod_reg_if.regs                bus
);

  // The register is eight bits wide, so no more flags fit.
  if (FLAG_W < 1 || FLAG_W > 8) begin : g_bad_width
    $error("FLAG_W must lie between 1 and 8.");
  end

  // Whole state of the flag register.
  typedef struct packed {
    logic [7:0] flags;
  } iod_flag_state_t;

  iod_flag_state_t st_q;  // Registered state.
  iod_flag_state_t st_d;  // Next state.
  logic [7:0]      set_w; // Set requests widened to the register.

  // Widened on purpose; unused upper flags stay clear.
  assign set_w       = 8'(i_set);
  assign bus.rd_data = st_q.flags;

  // A one clears its flag, a zero leaves it, and a set from hardware wins.
  always_comb begin
    st_d = st_q;
    if (bus.wr_en) begin
      st_d.flags = st_q.flags & ~(bus.wr_mask & bus.wr_data);
    end
    st_d.flags = st_d.flags | set_w;
  end

  // Registers the state, with a synchronous reset.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st_q.flags <= iod_pkg::FLAG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // A written zero never clears flag 0.
  zero_keeps_flag_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.wr_en && st_q.flags[0] && !(bus.wr_mask[0] && bus.wr_data[0]))
      |=> st_q.flags[0])
    else $error("Writing zero cleared a flag.");

  // A written one clears flag 0 unless hardware sets it again.
  one_clears_flag_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.wr_en && bus.wr_mask[0] && bus.wr_data[0] && !set_w[0])
      |=> !st_q.flags[0])
    else $error("Writing one did not clear a flag.");

endmodule

// *** tb/iod_per_model.sv ***
// Purpose: Peripheral side model that answers the decoder's read and write strobes.
// Assumes: Reads are answered in the same cycle as the read strobe.
// Notes:   Data addresses 0x1f0 and up are left unclaimed to act as a hole.
`timescale 1ns/1ps
module iod_per_model (
  input  wire logic       i_clk,
  input  wire logic       i_per_rd,
  input  wire logic       i_per_wr,
  input  wire logic [8:0] i_per_addr,
  input  wire logic [7:0] i_per_wdata,
  input  wire logic [7:0] i_per_wmask,
  output logic            o_per_hit,
  output logic      [7:0] o_per_rdata
);
  logic [7:0] mem_q [0:511];  // Peripheral register contents.
  logic       tog_q = 1'b0;   // Toggles every cycle to fill idle read data.
  logic       mapped;         // Address lies in the claimed range.

  // Claim the short and extended I/O space below the hole.
  assign mapped = (i_per_addr >= 9'h020) && (i_per_addr < 9'h1f0);

  // Start with cleared registers.
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem_q[i] = 8'h00;
    end
  end

  // Writes change only the bits under the mask.
  always @(posedge i_clk) begin
    tog_q <= ~tog_q;
    if (i_per_wr && mapped) begin
      mem_q[i_per_addr] <= (mem_q[i_per_addr] & ~i_per_wmask) | (i_per_wdata & i_per_wmask);
    end
  end

  // Unclaimed or idle reads show a changing pattern, never the last value.
  assign o_per_hit   = i_per_rd && mapped;
  assign o_per_rdata = o_per_hit ? mem_q[i_per_addr] : {4{tog_q, ~tog_q}};
endmodule

// *** tb/tb_io_space_address_decoder.sv ***
// Purpose: Self-checking bench of the I/O space address decoder.
// Assumes: Every answer comes exactly two cycles after the request is taken.
// Notes:   Inputs change on the falling edge; outputs are sampled there too.
`timescale 1ns/1ps
module tb_io_space_address_decoder;
  localparam logic [2:0] K_DAT = iod_pkg::IOD_K_DATA;  // Load or store.
  localparam logic [2:0] K_PRT = iod_pkg::IOD_K_PORT;  // Port in or out.
  localparam logic [2:0] K_SET = iod_pkg::IOD_K_BSET;  // Bit set.
  localparam logic [2:0] K_CLR = iod_pkg::IOD_K_BCLR;  // Bit clear.
  localparam logic [2:0] K_TS  = iod_pkg::IOD_K_TSET;  // Skip if set.
  localparam logic [2:0] K_TC  = iod_pkg::IOD_K_TCLR;  // Skip if clear.
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       i_acc_valid = 1'b0;
  logic [2:0] i_acc_kind = 3'h0;
  logic       i_acc_write = 1'b0;
  logic [8:0] i_acc_addr = 9'h000;
  logic [2:0] i_acc_bit = 3'h0;
  logic [7:0] i_acc_wdata = 8'h00;
  logic [7:0] i_flag_set = 8'h00;
  logic       per_hit, per_rd, per_wr, o_ack, o_bit_value, o_skip, o_refused;
  logic [7:0] per_rdata, per_wdata, per_wmask, o_rdata;
  logic [8:0] per_addr;
  logic [7:0] rd;           // Read data of the last answer.
  logic       bv, sk, rf;   // Bit value, skip and refusal of the last answer.
  int         error_cnt = 0;
  int         total_checks = 0;
  // Refused requests: kind and address.
  logic [2:0] rk [7] = '{K_SET, K_CLR, K_TS, K_PRT, K_DAT, 3'h6, 3'h7};
  logic [8:0] ra [7] = '{9'h02a, 9'h020, 9'h020, 9'h040, 9'h01f, 9'h01c, 9'h01c};

  always #10 i_clk = ~i_clk;

  iod_decoder DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_acc_valid(i_acc_valid),
    .i_acc_kind(i_acc_kind), .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
    .i_acc_bit(i_acc_bit), .i_acc_wdata(i_acc_wdata), .i_flag_set(i_flag_set),
    .i_per_hit(per_hit), .i_per_rdata(per_rdata), .o_per_rd(per_rd), .o_per_wr(per_wr),
    .o_per_addr(per_addr), .o_per_wdata(per_wdata), .o_per_wmask(per_wmask),
    .o_ack(o_ack), .o_rdata(o_rdata), .o_bit_value(o_bit_value), .o_skip(o_skip),
    .o_refused(o_refused));

  iod_per_model per (.i_clk(i_clk), .i_per_rd(per_rd), .i_per_wr(per_wr),
    .i_per_addr(per_addr), .i_per_wdata(per_wdata), .i_per_wmask(per_wmask),
    .o_per_hit(per_hit), .o_per_rdata(per_rdata));

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one byte.
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // Compares one bit.
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %b seen %b", nm, e, g);
      error_cnt++;
    end
  endtask

  // One request, entered at a falling edge; waits for the answer under a bound.
  task automatic acc(input logic [2:0] k, input logic w, input logic [8:0] a,
                     input logic [2:0] b, input logic [7:0] d);
    int n;
    i_acc_valid = 1'b1;
    i_acc_kind  = k;
    i_acc_write = w;
    i_acc_addr  = a;
    i_acc_bit   = b;
    i_acc_wdata = d;
    @(negedge i_clk);
    i_acc_valid = 1'b0;
    n = 1;
    while (o_ack !== 1'b1 && n < 6) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 6) begin
      $display("unexpected ack expected 1 seen timeout");
      error_cnt++;
      results();
    end else begin
      chk1("ack_cycle_two", 1'b1, n == 2);
      rd = o_rdata;
      bv = o_bit_value;
      sk = o_skip;
      rf = o_refused;
    end
  endtask

  // Reads and compares one location that must be accepted.
  task automatic rdchk(input logic [2:0] k, input logic [8:0] a, input logic [7:0] e);
    acc(k, 1'b0, a, 3'h0, 8'h00);
    chk8("read_data", e, rd);
    chk1("refused", 1'b0, rf);
  endtask

  // Storage and flag registers read zero after reset.
  task automatic t_reset();
    rdchk(K_DAT, 9'h03c, 8'h00);
    rdchk(K_DAT, 9'h03d, 8'h00);
    rdchk(K_DAT, 9'h04a, 8'h00);
    rdchk(K_DAT, 9'h04b, 8'h00);
    $display("test reset done");
  endtask

  // Storage registers seen through both address forms.
  task automatic t_scratch();
    acc(K_DAT, 1'b1, 9'h04a, 3'h0, 8'ha5);
    rdchk(K_PRT, 9'h02a, 8'ha5);
    acc(K_PRT, 1'b1, 9'h02b, 3'h0, 8'h5a);
    rdchk(K_DAT, 9'h04b, 8'h5a);
    acc(K_DAT, 1'b1, 9'h03c, 3'h0, 8'h81);
    rdchk(K_PRT, 9'h01c, 8'h81);
    $display("test scratch done");
  endtask

  // Bit set, clear and tests in the low range.
  task automatic t_bits();
    acc(K_SET, 1'b0, 9'h01c, 3'h3, 8'h00);
    acc(K_CLR, 1'b0, 9'h01c, 3'h0, 8'h00);
    rdchk(K_DAT, 9'h03c, 8'h88);
    acc(K_TS, 1'b0, 9'h01c, 3'h3, 8'h00);
    chk1("skip", 1'b1, sk);
    chk1("bit_value", 1'b1, bv);
    acc(K_TC, 1'b0, 9'h01c, 3'h3, 8'h00);
    chk1("skip", 1'b0, sk);
    acc(K_TC, 1'b0, 9'h01c, 3'h0, 8'h00);
    chk1("skip", 1'b1, sk);
    chk1("bit_value", 1'b0, bv);
    $display("test bits done");
  endtask

  // Requests outside their kind's range are refused and change nothing.
  task automatic t_refuse();
    for (int i = 0; i < 7; i++) begin
      acc(rk[i], 1'b1, ra[i], 3'h1, 8'h00);  // Byte data is zero; the bit set offers bit 1.
      chk1("refused", 1'b1, rf);
      chk8("read_data", 8'h00, rd);
      chk1("skip", 1'b0, sk);
    end
    rdchk(K_DAT, 9'h04a, 8'ha5);
    rdchk(K_DAT, 9'h03c, 8'h88);
    $display("test refuse done");
  endtask

  // Peripheral locations through port, data and bit paths.
  task automatic t_periph();
    acc(K_PRT, 1'b1, 9'h005, 3'h0, 8'h3c);
    rdchk(K_DAT, 9'h025, 8'h3c);
    acc(K_DAT, 1'b1, 9'h05f, 3'h0, 8'he7);
    rdchk(K_PRT, 9'h03f, 8'he7);
    acc(K_DAT, 1'b1, 9'h100, 3'h0, 8'hc3);
    rdchk(K_DAT, 9'h100, 8'hc3);
    acc(K_SET, 1'b0, 9'h005, 3'h0, 8'h00);
    rdchk(K_DAT, 9'h025, 8'h3d);
    rdchk(K_DAT, 9'h1f8, 8'h00);  // Hole is only read, never written.
    $display("test periph done");
  endtask

  // Write-one-to-clear flags under byte and bit writes.
  task automatic t_flags();
    i_flag_set = 8'h0f;
    @(negedge i_clk);
    i_flag_set = 8'h00;
    rdchk(K_DAT, 9'h03d, 8'h0f);
    acc(K_DAT, 1'b1, 9'h03d, 3'h0, 8'h05);
    rdchk(K_DAT, 9'h03d, 8'h0a);
    acc(K_SET, 1'b0, 9'h01d, 3'h1, 8'h00);
    rdchk(K_DAT, 9'h03d, 8'h08);
    acc(K_CLR, 1'b0, 9'h01d, 3'h3, 8'h00);
    acc(K_PRT, 1'b1, 9'h01d, 3'h0, 8'h00);
    rdchk(K_PRT, 9'h01d, 8'h08);
    $display("test flags done");
  endtask

  // A write and a read of the same register on consecutive cycles.
  task automatic t_b2b();
    i_acc_valid = 1'b1;
    i_acc_kind  = K_DAT;
    i_acc_write = 1'b1;
    i_acc_addr  = 9'h04b;
    i_acc_wdata = 8'h77;
    @(negedge i_clk);
    i_acc_write = 1'b0;
    @(negedge i_clk);
    i_acc_valid = 1'b0;
    chk1("ack", 1'b1, o_ack);
    chk8("read_data", 8'h00, o_rdata);
    @(negedge i_clk);
    chk1("ack", 1'b1, o_ack);
    chk8("read_data", 8'h77, o_rdata);
    $display("test b2b done");
  endtask

  // Reset for 20 cycles, then every scenario in turn.
  initial begin
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_scratch();
    t_bits();
    t_refuse();
    t_periph();
    t_flags();
    t_b2b();
    results();
  end
endmodule
